/* File: src/wdrc_pkg.sv */
// Functional notes
// RULE_01: Set test-port reset flag, bit 4, on test-port reset; clear by power-on or zero write.
// RULE_02: Set timeout reset flag, bit 3, on watchdog reset; clear by power-on or zero write.
// RULE_03: Set brown-out reset flag, bit 2, on brown-out; clear by power-on or zero write.
// RULE_04: Set pin reset flag, bit 1, on external reset; clear by power-on or zero write.
// RULE_05: Set power-on flag, bit 0, on power-on; only a zero write clears it.
// RULE_06: Legacy mode keeps only pin and power-on flags; others absent.
// RULE_07: Software should read then clear the flags early after start-up.
// RULE_08: Control bits 7:5 always read zero.
// RULE_09: Change window bit clears itself four clock cycles after being written one.
// RULE_10: Enable may be cleared only while the change window is open.
// RULE_11: Writing one to enable starts the watchdog; permitted zero stops it.
// RULE_12: Software disables by writing window and enable together, then zero within four.
// RULE_13: Levels 1 and 2 change prescaler only while the window is open.
// RULE_14: Level 2 keeps the watchdog enabled and ignores every disable attempt.
// RULE_15: Prescaler code n gives 16384 shifted left by n oscillator cycles.
// RULE_16: Timeout produces a one-clock internal reset pulse.
// RULE_17: Count restarts on restart command, on disable and on any chip reset.
// RULE_18: Level 2 reads enable as one.
// RULE_19: Counter advances on its own slow oscillator, about 1 MHz.
// RULE_20: Safety level comes from two static fuse inputs; level 2 starts enabled.
// RULE_21: Oscillator, fuses and events cross safely between the two timings.
package wdrc_pkg;

	// Register byte offsets
	localparam logic [7:0] ADDR_RESET_CAUSE = 8'h00;
	localparam logic [7:0] ADDR_WDOG_CTRL = 8'h04;

	// Reset cause field positions
	localparam int unsigned TP_FLAG_BIT = 4;
	localparam int unsigned TO_FLAG_BIT = 3;
	localparam int unsigned BO_FLAG_BIT = 2;
	localparam int unsigned PIN_FLAG_BIT = 1;
	localparam int unsigned POR_FLAG_BIT = 0;
	localparam logic [4:0] LEGACY_FLAG_MASK = 5'h03;
	localparam logic [4:0] FULL_FLAG_MASK = 5'h1f;
	localparam logic [4:0] FLAGS_RST = 5'h01;

	// Watchdog control field positions
	localparam int unsigned CHG_WIN_BIT = 4;
	localparam int unsigned ENABLE_BIT = 3;
	localparam int unsigned PRESCALE_W = 3;
	localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 3'h0;

	// Timing
	localparam int unsigned CHG_WINDOW_CYCLES = 4;
	localparam int unsigned TIMEOUT_BASE_DEFAULT = 16384;
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned OSC_HZ = 1_000_000;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		WDRC_LEVEL0 = 2'b00,
		WDRC_LEVEL1 = 2'b01,
		WDRC_LEVEL2 = 2'b10
	} wdrc_level_t;

	typedef enum logic [1:0] {
		WDRC_SEL_FLAGS = 2'b00,
		WDRC_SEL_CTRL = 2'b01,
		WDRC_SEL_NONE = 2'b10
	} wdrc_sel_t;

endpackage : wdrc_pkg

/* File: src/wdrc_timer.sv */
`timescale 1ns/1ps
module wdrc_timer
	import wdrc_pkg::*;
#(
	parameter int unsigned BASE_CYCLES = TIMEOUT_BASE_DEFAULT,
	parameter int unsigned CNT_W = 22
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Oscillator pin
	input wire logic osc_in,
	// Control
	input wire logic run,
	input wire logic restart,
	input wire logic [PRESCALE_W-1:0] prescale,
	// Event
	output logic timeout_pulse
);

	typedef struct packed {
		logic [2:0] osc_sync;
		logic [CNT_W-1:0] cnt;
		logic fire;
	} wdrc_tmr_state_t;

	wdrc_tmr_state_t q_ff;
	wdrc_tmr_state_t nxt_q;
	logic [CNT_W-1:0] limit;
	logic osc_rise;

	if (BASE_CYCLES < 2 || (64'(BASE_CYCLES) << 7) > (64'd1 << CNT_W)) begin : g_chk_w
		$error("wdrc_timer: BASE_CYCLES does not fit CNT_W");
	end
	// Edge detect needs the oscillator well below half the clock rate
	if (OSC_HZ * 2 >= CLK_HZ) begin : g_chk_osc
		$error("wdrc_timer: oscillator too fast for sampling");
	end

	assign limit = CNT_W'(BASE_CYCLES) << prescale; // see RULE_15
	assign osc_rise = q_ff.osc_sync[1] & ~q_ff.osc_sync[2];
	assign timeout_pulse = q_ff.fire;

	always_comb begin
		nxt_q = q_ff;
		nxt_q.fire = 1'b0;
		// Two-stage synchroniser, third stage only for the edge
		nxt_q.osc_sync = {q_ff.osc_sync[1:0], osc_in}; // see RULE_21
		if (!run || restart) begin
			nxt_q.cnt = '0; // see RULE_17
		end else if (osc_rise) begin // see RULE_19
			// Compare with >= so a shortened limit fires on the next oscillator edge
			if (q_ff.cnt >= limit - CNT_W'(1)) begin
				nxt_q.fire = 1'b1;
				nxt_q.cnt = '0;
			end else begin
				nxt_q.cnt = q_ff.cnt + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q_ff <= '0;
		end else begin
			q_ff <= nxt_q;
		end
	end

endmodule : wdrc_timer

/* File: src/wdrc_top.sv */
`timescale 1ns/1ps
module wdrc_top
	import wdrc_pkg::*;
#(
	parameter int unsigned TIMEOUT_BASE_CYCLES = TIMEOUT_BASE_DEFAULT,
	parameter int unsigned ADDR_W = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,

	// AXI4-Lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,

	// AXI4-Lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,

	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,

	// AXI4-Lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,

	// AXI4-Lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,

	// Reset sources, one-cycle pulses on aclk
	input wire logic power_on_evt,
	input wire logic pin_reset_evt,
	input wire logic brownout_evt,
	input wire logic test_port_reset_evt,

	// Watchdog restart command, one-cycle pulse
	input wire logic wdt_restart,

	// Static fuses, high when programmed
	input wire logic legacy_compat_fuse,
	input wire logic always_on_fuse,

	// Watchdog oscillator pin
	input wire logic wdt_osc,

	// Outputs
	output logic wdt_reset_pulse,
	output logic wdt_running
);

	////////////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		// Bus slave
		logic aw_got;
		logic [ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		// Fuse synchronisers
		logic [1:0] fuse_s1;
		logic [1:0] fuse_s2;
		// Reset cause flags
		logic [4:0] flags;
		// Watchdog control
		logic en;
		logic chg_win;
		logic [1:0] win_cnt;
		logic [PRESCALE_W-1:0] presc;
		// Internal reset pulse
		logic rst_pulse;
	} wdrc_state_t;

	localparam logic [1:0] WIN_LOAD = 2'(CHG_WINDOW_CYCLES - 1);

	if (CHG_WINDOW_CYCLES < 1 || CHG_WINDOW_CYCLES > 4) begin : g_chk_win
		$error("wdrc_top: window counter is two bits wide");
	end
	if (ADDR_W < 3) begin : g_chk_addr
		$error("wdrc_top: ADDR_W too small for the map");
	end

	wdrc_state_t q_ff;
	wdrc_state_t nxt_q;

	wdrc_level_t level;
	logic legacy;
	logic en_eff;
	logic timeout;
	logic chip_reset;
	logic wr_fire;
	logic [4:0] flag_mask;
	logic [4:0] flag_set;
	logic [4:0] flag_clr;
	logic [7:0] flags_rd;
	logic [7:0] ctrl_rd;

	////////////////////////////////////////////////////////////////////////////////

	function automatic wdrc_sel_t wdrc_decode(input logic [ADDR_W-1:0] addr);
		wdrc_sel_t sel;
		sel = WDRC_SEL_NONE;
		if (addr == ADDR_W'(ADDR_RESET_CAUSE)) begin
			sel = WDRC_SEL_FLAGS;
		end else if (addr == ADDR_W'(ADDR_WDOG_CTRL)) begin
			sel = WDRC_SEL_CTRL;
		end
		return sel;
	endfunction : wdrc_decode

	////////////////////////////////////////////////////////////////////////////////

	// Fuse decode; level reads 1 for the two settling cycles after reset
	always_comb begin
		legacy = q_ff.fuse_s2[1];
		if (q_ff.fuse_s2[0]) begin
			level = WDRC_LEVEL2; // see RULE_20
		end else if (legacy) begin
			level = WDRC_LEVEL0;
		end else begin
			level = WDRC_LEVEL1;
		end
	end

	assign en_eff = q_ff.en | (level == WDRC_LEVEL2); // see RULE_14
	assign flag_mask = legacy ? LEGACY_FLAG_MASK : FULL_FLAG_MASK; // see RULE_06
	assign chip_reset = power_on_evt | pin_reset_evt | brownout_evt | test_port_reset_evt
		| q_ff.rst_pulse;
	assign wr_fire = q_ff.aw_got & q_ff.w_got & ~q_ff.bvalid;

	// Hidden flags read as zero in legacy mode
	assign flags_rd = {3'h0, q_ff.flags & flag_mask};
	// Upper bits tie to zero, enable forced in level 2
	assign ctrl_rd = {3'h0, q_ff.chg_win, en_eff, q_ff.presc}; // see RULE_08, see RULE_18

	always_comb begin
		flag_set = '0;
		flag_set[TP_FLAG_BIT] = test_port_reset_evt; // see RULE_01
		flag_set[TO_FLAG_BIT] = q_ff.rst_pulse; // see RULE_02
		flag_set[BO_FLAG_BIT] = brownout_evt; // see RULE_03
		flag_set[PIN_FLAG_BIT] = pin_reset_evt; // see RULE_04
		flag_set[POR_FLAG_BIT] = power_on_evt; // see RULE_05
		flag_set = flag_set & flag_mask;
		flag_clr = '0;
		if (wr_fire && q_ff.w_lane0 && wdrc_decode(q_ff.aw_addr) == WDRC_SEL_FLAGS) begin
			flag_clr = ~q_ff.w_data[4:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	wdrc_timer #(
		.BASE_CYCLES(TIMEOUT_BASE_CYCLES),
		.CNT_W(22)
	) u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.osc_in(wdt_osc),
		.run(en_eff),
		.restart(wdt_restart | chip_reset), // see RULE_17
		.prescale(q_ff.presc),
		.timeout_pulse(timeout)
	);

	////////////////////////////////////////////////////////////////////////////////

	assign awready = ~q_ff.aw_got & ~q_ff.bvalid;
	assign wready = ~q_ff.w_got & ~q_ff.bvalid;
	assign bvalid = q_ff.bvalid;
	assign bresp = q_ff.bresp;
	assign arready = ~q_ff.rvalid;
	assign rvalid = q_ff.rvalid;
	assign rdata = {24'h0, q_ff.rdata};
	assign rresp = q_ff.rresp;
	assign wdt_reset_pulse = q_ff.rst_pulse;
	assign wdt_running = en_eff;

	always_comb begin
		nxt_q = q_ff;

		nxt_q.fuse_s1 = {legacy_compat_fuse, always_on_fuse}; // see RULE_21
		nxt_q.fuse_s2 = q_ff.fuse_s1;

		// One aclk cycle wide, taken straight from the timer event
		nxt_q.rst_pulse = timeout; // see RULE_16

		// Power-on wipes the others; otherwise set beats clear
		if (power_on_evt) begin
			nxt_q.flags = FLAGS_RST; // see RULE_05
		end else begin
			nxt_q.flags = (q_ff.flags & ~flag_clr) | flag_set; // see RULE_01, see RULE_02
		end

		// Change window countdown
		if (q_ff.chg_win) begin
			if (q_ff.win_cnt == 2'h0) begin
				nxt_q.chg_win = 1'b0; // see RULE_09
			end else begin
				nxt_q.win_cnt = q_ff.win_cnt - 2'h1;
			end
		end

		// Write channels
		if (awvalid && awready) begin
			nxt_q.aw_got = 1'b1;
			nxt_q.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			nxt_q.w_got = 1'b1;
			nxt_q.w_data = wdata[7:0];
			nxt_q.w_lane0 = wstrb[0];
		end
		if (q_ff.bvalid && bready) begin
			nxt_q.bvalid = 1'b0;
		end

		if (wr_fire) begin
			nxt_q.aw_got = 1'b0;
			nxt_q.w_got = 1'b0;
			nxt_q.bvalid = 1'b1;
			nxt_q.bresp = RESP_OKAY;
			if (wdrc_decode(q_ff.aw_addr) == WDRC_SEL_NONE) begin
				nxt_q.bresp = RESP_SLVERR;
			end else if (wdrc_decode(q_ff.aw_addr) == WDRC_SEL_CTRL && q_ff.w_lane0) begin
				// Opening write must carry enable too outside level 0
				if (q_ff.w_data[CHG_WIN_BIT]
						&& (level == WDRC_LEVEL0 || q_ff.w_data[ENABLE_BIT])) begin
					nxt_q.chg_win = 1'b1;
					nxt_q.win_cnt = WIN_LOAD;
				end else if (!q_ff.w_data[CHG_WIN_BIT]) begin
					nxt_q.chg_win = 1'b0;
				end
				if (q_ff.w_data[ENABLE_BIT]) begin
					nxt_q.en = 1'b1; // see RULE_11
				end else if (q_ff.chg_win && level != WDRC_LEVEL2) begin
					nxt_q.en = 1'b0; // see RULE_10, see RULE_14
				end
				if (level == WDRC_LEVEL0 || q_ff.chg_win) begin
					nxt_q.presc = q_ff.w_data[PRESCALE_W-1:0]; // see RULE_13
				end
			end
		end

		// Any chip reset returns the control to its initial state
		if (chip_reset) begin
			nxt_q.en = 1'b0;
			nxt_q.chg_win = 1'b0;
			nxt_q.win_cnt = 2'h0;
			nxt_q.presc = PRESCALE_RST;
		end

		// Read channel
		if (q_ff.rvalid && rready) begin
			nxt_q.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			nxt_q.rvalid = 1'b1;
			unique case (wdrc_decode(araddr))
				WDRC_SEL_FLAGS: begin
					nxt_q.rdata = flags_rd;
					nxt_q.rresp = RESP_OKAY;
				end
				WDRC_SEL_CTRL: begin
					nxt_q.rdata = ctrl_rd;
					nxt_q.rresp = RESP_OKAY;
				end
				default: begin
					nxt_q.rdata = 8'h00;
					nxt_q.rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q_ff <= '0;
			q_ff.flags <= FLAGS_RST;
			q_ff.presc <= PRESCALE_RST;
		end else begin
			q_ff <= nxt_q;
		end
	end

endmodule : wdrc_top

/* File: tb/wdrc_monitor.sv */
`timescale 1ns/1ps
module wdrc_monitor
	import wdrc_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus
	input wire logic awready,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic rvalid,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	// Watchdog
	input wire logic power_on_evt,
	input wire logic always_on_fuse,
	input wire logic wdt_reset_pulse,
	input wire logic wdt_running
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////
	a_pulse_single: assert property (wdt_reset_pulse |=> !wdt_reset_pulse)
		else $error("reset pulse too long");
	a_pulse_cause: assert property ($rose(wdt_reset_pulse) |-> $past(wdt_running))
		else $error("timeout while stopped");
	a_pulse_stops: assert property (wdt_reset_pulse && !always_on_fuse |=> !wdt_running)
		else $error("still running after timeout");
	a_level2_on: assert property (always_on_fuse [*5] |-> wdt_running)
		else $error("level 2 not running");
	a_por_stops: assert property (power_on_evt && !always_on_fuse |=> !wdt_running)
		else $error("running after power-on");
	a_rsv_zero: assert property (rvalid |-> rdata[31:5] == 27'h0)
		else $error("reserved bits not zero");
	a_slverr_zero: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
		else $error("error read with data");
	a_ready_held: assert property (bvalid |-> !awready && !wready)
		else $error("write taken during response");
	////////////////////
	cover property (wdt_reset_pulse);
	cover property (rvalid && rresp == RESP_SLVERR);
	cover property (wdt_running && always_on_fuse);
endmodule : wdrc_monitor

/* File: tb/wdrc_top_test.sv */
`timescale 1ns/1ps
module wdrc_top_test
	import wdrc_pkg::*;
;
	localparam logic [7:0] AF = ADDR_RESET_CAUSE;
	localparam logic [7:0] AC = ADDR_WDOG_CTRL;
	logic aclk, awready, wready, bvalid, arready, rvalid, wdt_reset_pulse, wdt_running;
	logic aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, bready = 1, rready = 1;
	logic wdt_restart = 0, legacy = 0, always_on = 0, wdt_osc = 0;
	logic [7:0] awaddr = 0, araddr = 0, ua;
	logic [31:0] wdata = 0, rdata;
	logic [3:0] wstrb = 4'hf, evt = 0;
	logic [1:0] bresp, rresp;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int err_total = 0, tests_run = 0, i;
	wdrc_top #(.TIMEOUT_BASE_CYCLES(4)) uut (.aclk, .aresetn, .awvalid, .awready, .awaddr,
		.wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
		.araddr, .rvalid, .rready, .rdata, .rresp, .power_on_evt(evt[0]),
		.pin_reset_evt(evt[1]), .brownout_evt(evt[2]), .test_port_reset_evt(evt[3]),
		.wdt_restart, .legacy_compat_fuse(legacy), .always_on_fuse(always_on), .wdt_osc,
		.wdt_reset_pulse, .wdt_running);
	////////////////////
	task automatic wrap_up();
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(string nm, logic [33:0] e, logic [33:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("Error %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic tmo();
		err_total++;
		wrap_up();
	endtask : tmo
	// Both channels offered together, each dropped once taken
	task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
		logic pa, pw, db, ta, tw;
		int n;
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		pa = 1;
		pw = 1;
		db = 0;
		for (n = 0; n < 50 && !db; n++) begin
			@(negedge aclk);
			ta = pa && awready;
			tw = pw && wready;
			db = bvalid;
			@(posedge aclk);
			// Drive only on release, so a following call owns the next edge alone
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		if (!db) tmo();
	endtask : wr
	task automatic rd(logic [7:0] a, logic [33:0] e);
		logic pa, db, ta;
		int n;
		rq.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		pa = 1;
		db = 0;
		for (n = 0; n < 50 && !db; n++) begin
			@(negedge aclk);
			ta = pa && arready;
			db = rvalid;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			pa = pa && !ta;
		end
		if (!db) tmo();
	endtask : rd
	task automatic run_is(logic e);
		@(negedge aclk);
		chk("running", {33'h0, e}, {33'h0, wdt_running});
		@(posedge aclk);
	endtask : run_is
	task automatic ev(int b);
		evt <= 4'h1 << b;
		@(posedge aclk);
		evt <= 4'h0;
		@(posedge aclk);
	endtask : ev
	// Osc is stopped between calls, so counts start clean
	task automatic osc(int edges, int rst_at, int e);
		int k, hit;
		hit = 0;
		for (k = 0; k < edges * 20; k++) begin
			@(negedge aclk);
			if (wdt_reset_pulse && hit == 0) hit = k / 20;
			@(posedge aclk);
			// Last step drives low, so the pin idles between calls
			wdt_osc <= (k + 1 < edges * 20) && (((k + 1) % 20) < 10);
			wdt_restart <= (k == rst_at * 20 + 4);
		end
		chk("timeout_edge", 34'(e), 34'(hit));
	endtask : osc
	task automatic boot(logic leg, logic aon);
		legacy <= leg;
		always_on <= aon;
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
	endtask : boot
	////////////////////
	always @(negedge aclk) begin
		if (rvalid && rready && rq.size() > 0) chk("rdata", rq.pop_front(), {rresp, rdata});
		if (bvalid && bready && bq.size() > 0) chk("bresp", 34'(bq.pop_front()), 34'(bresp));
	end
	initial begin
		aclk = 0;
		forever #25 aclk = ~aclk;
	end
	initial begin
		repeat (100000) @(posedge aclk);
		tmo();
	end
	initial begin
		void'($urandom(32'hc1a0));
		ua = 8'h08 + 8'(4 * ($urandom % 60));
		boot(0, 0);
		rd(AF, 34'h01);
		wr(AF, 32'h0, RESP_OKAY);
		rd(AF, 34'h00);
		for (i = 1; i < 4; i++) ev(i);
		wr(AF, $urandom | 32'h1f, RESP_OKAY);
		rd(AF, 34'h16);
		ev(0);
		rd(AF, 34'h01);
		// Lane 0 off: the zero must not clear anything
		wstrb <= 4'he;
		wr(AF, 32'h0, RESP_OKAY);
		wstrb <= 4'hf;
		rd(AF, 34'h01);
		wr(ua, $urandom, RESP_SLVERR);
		rd(ua, {RESP_SLVERR, 32'h0});
		$display("test flags done");
		wr(AC, 32'h08, RESP_OKAY);
		rd(AC, 34'h08);
		wr(AC, 32'he1, RESP_OKAY);
		rd(AC, 34'h08);
		wr(AC, 32'h18, RESP_OKAY);
		wr(AC, 32'h09, RESP_OKAY);
		rd(AC, 34'h09);
		wr(AC, 32'h18, RESP_OKAY);
		rd(AC, 34'h19);
		wr(AC, 32'h00, RESP_OKAY);
		rd(AC, 34'h09);
		wr(AC, 32'h18, RESP_OKAY);
		wr(AC, 32'h00, RESP_OKAY);
		rd(AC, 34'h00);
		run_is(1'b0);
		wr(AC, 32'h08, RESP_OKAY);
		// Restart lands after the third counted edge, so the fourth comes late
		osc(8, 2, 6);
		rd(AF, 34'h09);
		wr(AC, 32'h08, RESP_OKAY);
		run_is(1'b1);
		ev(0);
		run_is(1'b0);
		$display("test level1 done");
		boot(1, 0);
		for (i = 1; i < 4; i++) ev(i);
		rd(AF, 34'h03);
		wr(AC, 32'h09, RESP_OKAY);
		osc(9, 0, 8);
		rd(AF, 34'h03);
		$display("test level0 done");
		boot(0, 1);
		rd(AC, 34'h08);
		wr(AC, 32'h18, RESP_OKAY);
		wr(AC, 32'h00, RESP_OKAY);
		rd(AC, 34'h08);
		wr(AC, 32'h01, RESP_OKAY);
		rd(AC, 34'h08);
		osc(5, 0, 4);
		run_is(1'b1);
		$display("test level2 done");
		wrap_up();
	end
endmodule : wdrc_top_test

bind wdrc_top wdrc_monitor mon (.aclk, .aresetn, .awready, .wready, .bvalid, .rvalid,
	.rdata, .rresp, .power_on_evt, .always_on_fuse, .wdt_reset_pulse, .wdt_running);
